// ---- verilog/rij_defs.svh ----
// timing counts and constants for the relative and indirect jump unit
// assumes one clock state per cycle of i_sys_clk
`ifndef RIJ_DEFS_SVH
`define RIJ_DEFS_SVH
`define RIJ_T_FETCH    3'h4
`define RIJ_T_FETCH_DEC 3'h5
`define RIJ_T_DISP     3'h3
`define RIJ_T_ADD      3'h5
`define RIJ_T_PREFIX   3'h4
`define RIJ_T_ONE      3'h1
`define RIJ_PC_STEP    16'h0002
`define RIJ_ADDR_STEP  16'h0001
`define RIJ_COUNT_STEP 8'h01
`endif

// ---- verilog/rij_pkg.sv ----
// types for the relative and indirect jump unit
// assumes rij_defs.svh is on the include path
`default_nettype none
package rij_pkg;
   typedef enum logic [2:0] {
      RIJ_OP_JR_NC,
      RIJ_OP_JR_Z,
      RIJ_OP_JR_NZ,
      RIJ_OP_JP_MAIN,
      RIJ_OP_JP_IDX1,
      RIJ_OP_JP_IDX2,
      RIJ_OP_DECREMENT_BRANCH_NONZERO
   } rij_op_t;
   typedef enum logic [1:0] {
      RIJ_MC_IDLE,
      RIJ_MC_ONE,
      RIJ_MC_TWO,
      RIJ_MC_THREE
   } rij_mcyc_t;
endpackage
`default_nettype wire

// ---- verilog/rij_unit.sv ----
// execution of relative, indirect and loop branch instructions
// assumes the opcode is already decoded and memory answers within its read cycle
`include "rij_defs.svh"
`default_nettype none
module rij_unit (
   input  wire logic           i_sys_clk,
   input  wire logic           i_rstn,
   input  wire logic           i_start,
   input  wire rij_pkg::rij_op_t i_op,
   input  wire logic [15:0]    i_opcode_addr,
   input  wire logic           i_carry,
   input  wire logic           i_zero,
   input  wire logic [7:0]     i_count,
   input  wire logic [15:0]    i_main_ptr,
   input  wire logic [15:0]    i_idx_first,
   input  wire logic [15:0]    i_idx_second,
   input  wire logic [7:0]     i_mem_data,
   output logic                o_busy,
   output logic                o_mem_rd,
   output logic [15:0]         o_mem_addr,
   output logic                o_done,
   output logic                o_taken,
   output logic [15:0]         o_pc,
   output logic [7:0]          o_count,
   output logic                o_count_wr,
   output logic                o_carry,
   output logic                o_zero
);
   import rij_pkg::*;

   logic        rst_meta_reg;
   logic        rst_sync_reg;
   rij_mcyc_t   mcyc_reg;
   logic [2:0]  tcnt_reg;
   rij_op_t     op_reg;
   logic [15:0] pc_reg;
   logic [15:0] ptr_reg;
   logic [7:0]  disp_reg;
   logic [7:0]  count_reg;
   logic        carry_reg;
   logic        zero_reg;
   logic        busy_reg;
   logic        mem_rd_reg;
   logic [15:0] mem_addr_reg;
   logic        done_reg;
   logic        taken_reg;
   logic [15:0] new_pc_reg;
   logic        count_wr_reg;

   // reset is released through two flops so no flop sees a ragged release
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   wire        rstn_s    = rst_sync_reg;
   wire        last_t    = (tcnt_reg == 3'h0);
   wire        legal_op  = (i_op <= RIJ_OP_DECREMENT_BRANCH_NONZERO);
   wire        accept    = (mcyc_reg == RIJ_MC_IDLE) && i_start && legal_op;
   wire        is_decrement_branch_nonzero   = (op_reg == RIJ_OP_DECREMENT_BRANCH_NONZERO);
   wire        is_idx    = (op_reg == RIJ_OP_JP_IDX1) || (op_reg == RIJ_OP_JP_IDX2);
   wire        is_main   = (op_reg == RIJ_OP_JP_MAIN);
   wire        one_end   = (mcyc_reg == RIJ_MC_ONE) && last_t;
   wire        two_end   = (mcyc_reg == RIJ_MC_TWO) && last_t;
   wire        three_end = (mcyc_reg == RIJ_MC_THREE) && last_t;
   wire [15:0] disp_ext  = {{8{disp_reg[7]}}, disp_reg};
   wire [15:0] seq_pc    = pc_reg + `RIJ_PC_STEP;
   wire [15:0] target_pc = seq_pc + disp_ext;
   wire [7:0]  count_dec = count_reg - `RIJ_COUNT_STEP;
   // flags are latched at start; the decision waits for the displacement byte
   wire        cond_met  = (op_reg == RIJ_OP_JR_NC) ? !carry_reg :
                           (op_reg == RIJ_OP_JR_Z)  ? zero_reg :
                           (op_reg == RIJ_OP_JR_NZ) ? !zero_reg :
                           (count_reg != 8'h00);
   wire        finish    = (one_end && is_main) || (two_end && (is_idx || !cond_met))
                           || three_end;
   wire [15:0] ptr_sel   = (i_op == RIJ_OP_JP_IDX1) ? i_idx_first :
                           (i_op == RIJ_OP_JP_IDX2) ? i_idx_second : i_main_ptr;
   wire [15:0] finish_pc = (is_main || is_idx) ? ptr_reg :
                           three_end ? target_pc : seq_pc;
   wire [2:0]  t_first   = (i_op == RIJ_OP_DECREMENT_BRANCH_NONZERO) ? `RIJ_T_FETCH_DEC : `RIJ_T_FETCH;

   always_ff @(posedge i_sys_clk or negedge rstn_s) begin
      if (!rstn_s) begin
         mcyc_reg   <= RIJ_MC_IDLE;
         tcnt_reg   <= 3'h0;
         busy_reg   <= 1'b0;
         mem_rd_reg <= 1'b0;
      end else begin
         // the counter free-runs when idle; only its value at a state's end matters
         tcnt_reg <= tcnt_reg - `RIJ_T_ONE;
         unique case (mcyc_reg)
            RIJ_MC_IDLE: begin
               if (accept) begin
                  mcyc_reg <= RIJ_MC_ONE;
                  tcnt_reg <= t_first - `RIJ_T_ONE;
                  busy_reg <= 1'b1;
               end
            end
            RIJ_MC_ONE: begin
               if (last_t && is_main) begin
                  mcyc_reg <= RIJ_MC_IDLE;
                  busy_reg <= 1'b0;
               end else if (last_t) begin
                  mcyc_reg   <= RIJ_MC_TWO;
                  tcnt_reg   <= (is_idx ? `RIJ_T_PREFIX : `RIJ_T_DISP) - `RIJ_T_ONE;
                  mem_rd_reg <= !is_idx;
               end
            end
            RIJ_MC_TWO: begin
               if (last_t) begin
                  mem_rd_reg <= 1'b0;
                  if (!is_idx && cond_met) begin
                     mcyc_reg <= RIJ_MC_THREE;
                     tcnt_reg <= `RIJ_T_ADD - `RIJ_T_ONE;
                  end else begin
                     mcyc_reg <= RIJ_MC_IDLE;
                     busy_reg <= 1'b0;
                  end
               end
            end
            RIJ_MC_THREE: begin
               if (last_t) begin
                  mcyc_reg <= RIJ_MC_IDLE;
                  busy_reg <= 1'b0;
               end
            end
         endcase
      end
   end

   // operands are caught at start so the caller may move on while we run
   always_ff @(posedge i_sys_clk or negedge rstn_s) begin
      if (!rstn_s) begin
         op_reg       <= RIJ_OP_JR_NC;
         pc_reg       <= 16'h0000;
         ptr_reg      <= 16'h0000;
         carry_reg    <= 1'b0;
         zero_reg     <= 1'b0;
         mem_addr_reg <= 16'h0000;
      end else if (accept) begin
         op_reg       <= i_op;
         pc_reg       <= i_opcode_addr;
         ptr_reg      <= ptr_sel;
         carry_reg    <= i_carry;
         zero_reg     <= i_zero;
         mem_addr_reg <= i_opcode_addr + `RIJ_ADDR_STEP;
      end
   end

   always_ff @(posedge i_sys_clk or negedge rstn_s) begin
      if (!rstn_s) begin
         count_reg <= 8'h00;
         disp_reg  <= 8'h00;
      end else begin
         if (accept) begin
            count_reg <= i_count;
         end else if (one_end && is_decrement_branch_nonzero) begin
            count_reg <= count_dec;
         end
         if (two_end && !is_idx) begin
            disp_reg <= i_mem_data;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge rstn_s) begin
      if (!rstn_s) begin
         done_reg     <= 1'b0;
         taken_reg    <= 1'b0;
         new_pc_reg   <= 16'h0000;
         count_wr_reg <= 1'b0;
      end else begin
         done_reg     <= finish;
         count_wr_reg <= finish && is_decrement_branch_nonzero;
         if (finish) begin
            taken_reg  <= three_end || is_main || is_idx;
            new_pc_reg <= finish_pc;
         end
      end
   end

   assign o_busy     = busy_reg;
   assign o_mem_rd   = mem_rd_reg;
   assign o_mem_addr = mem_addr_reg;
   assign o_done     = done_reg;
   assign o_taken    = taken_reg;
   assign o_pc       = new_pc_reg;
   assign o_count    = count_reg;
   assign o_count_wr = count_wr_reg;
   // flags only ever echo what was latched, none is written
   assign o_carry    = carry_reg;
   assign o_zero     = zero_reg;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!rstn_s);

   sequence s_go(rij_op_t op);
      accept && (i_op == op);
   endsequence
   sequence s_jump_done;
      o_done && o_taken;
   endsequence
   sequence s_skip_done;
      o_done && !o_taken;
   endsequence

   nc_taken_a: assert property (s_go(RIJ_OP_JR_NC) and !i_carry |-> ##13 s_jump_done)
      else $error("carry clear jump not taken in 12 states");
   nc_skip_a: assert property (s_go(RIJ_OP_JR_NC) and i_carry |-> ##8 s_skip_done)
      else $error("carry set jump not skipped in 7 states");
   z_taken_a: assert property (s_go(RIJ_OP_JR_Z) and i_zero |-> ##13 s_jump_done)
      else $error("zero set jump not taken in 12 states");
   z_skip_a: assert property (s_go(RIJ_OP_JR_Z) and !i_zero |-> ##8 s_skip_done)
      else $error("zero clear jump not skipped");
   nz_taken_a: assert property (s_go(RIJ_OP_JR_NZ) and !i_zero |-> ##13 s_jump_done)
      else $error("zero clear condition jump not taken");
   nz_skip_a: assert property (s_go(RIJ_OP_JR_NZ) and i_zero |-> ##8 s_skip_done)
      else $error("zero clear condition jump not skipped");
   rel_range_a: assert property (o_done && o_taken && !is_main && !is_idx |->
      ($signed(o_pc - pc_reg) >= -126) && ($signed(o_pc - pc_reg) <= 129))
      else $error("relative target out of range");
   rel_target_a: assert property (o_done && o_taken && !is_main && !is_idx |->
      o_pc == pc_reg + 16'h0002 + {{8{disp_reg[7]}}, disp_reg})
      else $error("relative target not from opcode address plus two");
   skip_pc_a: assert property (s_skip_done |-> o_pc == pc_reg + 16'h0002)
      else $error("fall through address wrong");
   busy_len_a: assert property (s_go(RIJ_OP_JR_Z) |=> o_busy [*7])
      else $error("branch busy less than 7 states");
   main_jump_a: assert property (s_go(RIJ_OP_JP_MAIN) |-> ##5 (s_jump_done and
      o_pc == $past(i_main_ptr, 5)))
      else $error("main pointer jump wrong");
   idx1_jump_a: assert property (s_go(RIJ_OP_JP_IDX1) |-> ##9 (s_jump_done and
      o_pc == $past(i_idx_first, 9)))
      else $error("first index jump wrong");
   idx2_jump_a: assert property (s_go(RIJ_OP_JP_IDX2) |-> ##9 (s_jump_done and
      o_pc == $past(i_idx_second, 9)))
      else $error("second index jump wrong");
   loop_taken_a: assert property (s_go(RIJ_OP_DECREMENT_BRANCH_NONZERO) and i_count != 8'h01 |->
      ##14 (s_jump_done and o_count_wr and o_count == $past(i_count, 14) - 8'h01))
      else $error("loop branch not taken in 13 states");
   loop_exit_a: assert property (s_go(RIJ_OP_DECREMENT_BRANCH_NONZERO) and i_count == 8'h01 |->
      ##9 (s_skip_done and o_count_wr and o_count == 8'h00))
      else $error("loop exit not in 8 states");
   flags_keep_a: assert property (o_busy |=> $stable(o_carry) && $stable(o_zero))
      else $error("flag changed during branch");
   mem_rd_a: assert property (o_mem_rd && !$past(o_mem_rd) |->
      o_mem_rd [*3] ##1 !o_mem_rd)
      else $error("displacement read not 3 states");

   // state counts are checked where busy drops, so they hold even if done were late
   sequence s_busy_drop;
      o_busy ##1 !o_busy;
   endsequence
   main_busy_a: assert property (s_go(RIJ_OP_JP_MAIN) |-> ##4 s_busy_drop)
      else $error("main pointer jump busy not 4 states");
   idx1_busy_a: assert property (s_go(RIJ_OP_JP_IDX1) |-> ##8 s_busy_drop)
      else $error("first index jump busy not 8 states");
   idx2_busy_a: assert property (s_go(RIJ_OP_JP_IDX2) |-> ##8 s_busy_drop)
      else $error("second index jump busy not 8 states");
   rel_busy_a: assert property (s_go(RIJ_OP_JR_NZ) and !i_zero |-> ##12 s_busy_drop)
      else $error("taken jump busy not 12 states");
   skip_busy_a: assert property (s_go(RIJ_OP_JR_NC) and i_carry |-> ##7 s_busy_drop)
      else $error("failed jump busy not 7 states");
   loop_busy_a: assert property (s_go(RIJ_OP_DECREMENT_BRANCH_NONZERO) and i_count != 8'h01 |->
      ##13 s_busy_drop)
      else $error("loop branch busy not 13 states");
   exit_busy_a: assert property (s_go(RIJ_OP_DECREMENT_BRANCH_NONZERO) and i_count == 8'h01 |->
      ##8 s_busy_drop)
      else $error("loop exit busy not 8 states");
   idx1_no_rd_a: assert property (s_go(RIJ_OP_JP_IDX1) |=> !o_mem_rd [*8])
      else $error("first index jump read memory");
   idx2_no_rd_a: assert property (s_go(RIJ_OP_JP_IDX2) |=> !o_mem_rd [*8])
      else $error("second index jump read memory");
   rd_addr_a: assert property (o_mem_rd |-> o_mem_addr == pc_reg + 16'h0001)
      else $error("displacement not read after opcode");
   wr_with_done_a: assert property (o_count_wr |-> o_done && is_decrement_branch_nonzero)
      else $error("count write outside loop end");
endmodule
`default_nettype wire

// ---- test/rij_mem_model.sv ----
// program memory model that answers displacement reads
// assumes the unit holds address and read strobe for three cycles
`default_nettype none
module rij_mem_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rd,
   input  wire logic [15:0] i_addr,
   output logic [7:0]       o_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0] cnt_reg = 2'h0;
   logic [7:0] last_reg = 8'h00;
   // slow memory: byte is valid only in the third read cycle, else the inverse of the last
   assign o_data = (i_rd && cnt_reg == 2'h2) ? i_addr[7:0] : ~last_reg;
   always @(posedge i_sys_clk) begin
      cnt_reg <= i_rd ? cnt_reg + 2'h1 : 2'h0;
      if (i_rd && cnt_reg == 2'h2) last_reg <= i_addr[7:0];
   end
endmodule
`default_nettype wire

// ---- test/test_rij_unit.sv ----
// self-checking bench for the branch execution unit
// assumes memory byte at address a is a[7:0], so the displacement follows the opcode address
`default_nettype none
module test_rij_unit;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {
      logic [15:0] pc;
      logic        tk, c, z, cw;
      logic [7:0]  n;
      int          cyc, nb, nr;
   } rij_note_t;
   logic clk = 1'b0, rstn = 1'b0, start = 1'b0, c = 1'b0, z = 1'b0;
   logic busy, rd, done, tk, cw, oc, oz;
   logic [2:0] op = 3'h0;
   logic [15:0] a = 16'h0, p1 = 16'h0, p2 = 16'h0, p3 = 16'h0, ma, pc;
   logic [7:0] n = 8'h0, md, on;
   logic [15:0] r = 16'h005b;
   int cyc = 0, fail_count = 0, checked = 0, nb = 0, nr = 0;
   rij_note_t q[$];
   rij_note_t m;
   always #25 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   rij_unit DUT (.i_sys_clk(clk), .i_rstn(rstn), .i_start(start), .i_op(rij_pkg::rij_op_t'(op)),
      .i_opcode_addr(a), .i_carry(c), .i_zero(z), .i_count(n), .i_main_ptr(p1),
      .i_idx_first(p2), .i_idx_second(p3), .i_mem_data(md), .o_busy(busy), .o_mem_rd(rd),
      .o_mem_addr(ma), .o_done(done), .o_taken(tk), .o_pc(pc), .o_count(on),
      .o_count_wr(cw), .o_carry(oc), .o_zero(oz));
   rij_mem_model MEM (.i_sys_clk(clk), .i_rd(rd), .i_addr(ma), .o_data(md));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task report_and_stop;
      $display("checked %0d failed %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // start stays high with junk while busy, so any take in mid-instruction shows as extra done
   task issue(input int t);
      int k;
      rij_note_t e;
      logic [15:0] d;
      k = 0;
      do begin
         @(negedge clk);
         k++;
         if (busy !== 1'b0) begin
            r = lfsr(r);
            op = r[2:0];
         end
      end while (busy !== 1'b0 && k < 40);
      if (busy !== 1'b0) begin
         fail_count++;
         report_and_stop();
      end else begin
         r = lfsr(r);
         op = 3'(t % 7);
         a = {r[15:8], t < 14 ? (t[0] ? 8'h7f : 8'h7e) : r[7:0]};
         c = t < 14 ? t >= 7 : r[3];
         z = t < 14 ? t >= 7 : r[4];
         n = t < 7 ? 8'h01 : t < 14 ? 8'h00 : r[11:4];
         p1 = ~r;
         p2 = {r[7:0], r[15:8]};
         p3 = r ^ 16'h3c3c;
         start = 1'b1;
         d = a + 16'h0001;
         e.c = c;
         e.z = z;
         e.n = n - 8'h01;
         e.cw = op == 3'h6;
         e.tk = op == 3'h0 ? !c : op == 3'h1 ? z : op == 3'h2 ? !z : op == 3'h6 ? e.n != 0 : 1'b1;
         e.pc = a + 16'h0002;
         if (e.tk) e.pc = e.pc + {{8{d[7]}}, d[7:0]};
         if (op == 3'h3) e.pc = p1;
         if (op == 3'h4) e.pc = p2;
         if (op == 3'h5) e.pc = p3;
         e.nb = e.tk ? 12 : 7;
         if (op == 3'h6) e.nb = e.tk ? 13 : 8;
         if (op == 3'h3) e.nb = 4;
         if (op == 3'h4 || op == 3'h5) e.nb = 8;
         e.nr = (op < 3'h3 || op == 3'h6) ? 3 : 0;
         // done shows in the last of nb+1 edges counted from this falling edge
         e.cyc = cyc + 1 + e.nb;
         q.push_back(e);
         $display("test %0d issued op %0d", t, op);
      end
   endtask
   always @(negedge clk) begin
      if (done === 1'b1) begin
         if (q.size() == 0) check(32'h1, 32'h0);
         else begin
            m = q.pop_front();
            check(cyc, m.cyc);
            check(tk, m.tk);
            check(pc, m.pc);
            check({oc, oz}, {m.c, m.z});
            check(cw, m.cw);
            if (m.cw) check(on, m.n);
            check(nb, m.nb);
            check(nr, m.nr);
         end
         nb = 0;
         nr = 0;
      end else begin
         nb += (busy === 1'b1);
         nr += (rd === 1'b1);
      end
   end
   initial begin
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      for (int t = 0; t < 42; t++) issue(t);
      @(negedge clk);
      start = 1'b0;
      for (int k = 0; k < 30 && busy !== 1'b0; k++) @(negedge clk);
      op = 3'h7;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (20) @(negedge clk);
      check(busy, 1'b0);
      $display("test refused op done");
      check(q.size(), 0);
      report_and_stop();
   end
endmodule
`default_nettype wire
